// [verif/hreg_slave_chk.sv]
// checker: port properties of the serial holding-register slave
`timescale 1ns/1ns
module hreg_slave_chk
  import hreg_pkg::*;
#(
  parameter int unsigned GAP_LIMIT = GAP_CYCLES
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        slave_id_load,
  input wire logic [7:0]  slave_id_value,
  input wire logic        drive_board_lost,
  input wire logic [7:0]  slave_id_now,
  input wire logic [15:0] system_status
);
  logic [31:0] quiet_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycles since rxd was last low; saturates so a long idle cannot wrap
  always_ff @(posedge ref_clk) begin
    if (rst || !rxd) quiet_cnt <= 32'h0000_0000;
    else if (quiet_cnt < GAP_LIMIT) quiet_cnt <= quiet_cnt + 32'h0000_0001;
  end
  sequence s_start_bit; !txd [*8]; endsequence
  sequence s_lost_held; (clk_en && drive_board_lost) [*3]; endsequence
  sequence s_ok_held; (clk_en && !drive_board_lost) [*3]; endsequence
  property p_start; $fell(txd) |-> s_start_bit; endproperty
  property p_gap; $fell(txd) |-> quiet_cnt >= GAP_LIMIT; endproperty
  property p_quiet; !rxd |-> txd; endproperty
  property p_reset;
    $fell(rst) |-> slave_id_now == SLAVE_ID_RESET && system_status == STATUS_OK;
  endproperty
  property p_id_load; clk_en && slave_id_load |=> slave_id_now == $past(slave_id_value); endproperty
  property p_id_hold; clk_en && !slave_id_load |=> $stable(slave_id_now); endproperty
  property p_lost; s_lost_held |-> system_status == STATUS_LINK_LOST; endproperty
  property p_ok; s_ok_held |-> system_status == STATUS_OK; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  a_gap: assert property (p_gap) else $error("reply before frame gap");
  a_quiet: assert property (p_quiet) else $error("talks while receiving");
  a_reset: assert property (p_reset) else $error("bad reset values");
  a_id_load: assert property (p_id_load) else $error("address not loaded");
  a_id_hold: assert property (p_id_hold) else $error("address drifted");
  a_lost: assert property (p_lost) else $error("loss not flagged");
  a_ok: assert property (p_ok) else $error("status not zero");
endmodule
bind hreg_slave hreg_slave_chk #(.GAP_LIMIT(GAP_LIMIT)) chk_u (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .rxd(rxd), .txd(txd), .slave_id_load(slave_id_load),
  .slave_id_value(slave_id_value), .drive_board_lost(drive_board_lost),
  .slave_id_now(slave_id_now), .system_status(system_status));

// [verif/modbus_master.sv]
// partner model: polling master that frames requests and collects replies
`timescale 1ns/1ns
module modbus_master
  import hreg_pkg::*;
#(
  parameter int unsigned BIT_LEN = BIT_CYCLES
)
(
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;
  initial rxd = 1'b1; // idles at mark, never floated
  // crc-16 with the reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // start, eight bits lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_LEN) @(posedge ref_clk);
    end
  endtask
  // crc low byte first; bad flips a bit to provoke a refusal
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) send_byte(q[i]); // back to back, far inside the byte gap
  endtask
  // samples each reply bit at its centre
  initial forever begin
    @(negedge txd);
    repeat (BIT_LEN / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_LEN) @(posedge ref_clk);
      rb[i] = txd;
    end
    repeat (BIT_LEN) @(posedge ref_clk);
    rx_q.push_back(rb);
  end
endmodule

// [verif/testbench.sv]
// testbench: polls the slave over its serial port and drives its side inputs
`timescale 1ns/1ns
module testbench;
  import hreg_pkg::*;
  localparam int unsigned BIT_LEN = 16;
  localparam int unsigned GAP     = 400;
  localparam int unsigned BYTE_T  = 10 * BIT_LEN;
  logic        ref_clk, rst, clk_en, rxd, txd, id_load, upd, lost;
  logic [31:0] epoch;
  logic [15:0] speed, current, status;
  logic [7:0]  id_val, id_now;
  int          errors, total_checks;
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // short bit time and frame gap keep the run brief; the gap still exceeds a byte
  hreg_slave #(.GAP_LIMIT(GAP), .BIT_LEN(BIT_LEN)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .rxd(rxd), .txd(txd), .epoch_seconds(epoch), .slave_id_load(id_load),
    .slave_id_value(id_val), .drive_board_update(upd), .drive_board_speed(speed),
    .drive_board_current(current), .drive_board_lost(lost), .slave_id_now(id_now),
    .system_status(status));
  modbus_master #(.BIT_LEN(BIT_LEN)) mst_u (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  // compare helpers
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic ask(input logic [7:0] id, input logic [7:0] st, input logic [7:0] n,
                     input logic bad);
    mst_u.send_frame('{id, FUNC_READ_HOLD, 8'h00, st, 8'h00, n}, bad);
  endtask
  // waits bounded for the reply, then checks header, words and crc
  task automatic expect_reply(input logic [7:0] id, input logic [15:0] w[$]);
    int n;
    n = 5 + 2 * w.size();
    for (int i = 0; mst_u.rx_q.size() < n; i++) begin
      if (i > GAP + (n + 10) * BYTE_T) begin
        errors++;
        $display("MISMATCH t=%0t no reply", $time);
        wrap_up();
      end
      @(posedge ref_clk);
    end
    repeat (2 * BYTE_T) @(posedge ref_clk);
    chk_word(16'(mst_u.rx_q.size()), 16'(n));
    chk_byte(mst_u.rx_q[0], id);
    chk_byte(mst_u.rx_q[1], FUNC_READ_HOLD);
    chk_byte(mst_u.rx_q[2], 8'(2 * w.size()));
    foreach (w[i]) begin
      chk_byte(mst_u.rx_q[3 + 2 * i], w[i][15:8]);
      chk_byte(mst_u.rx_q[4 + 2 * i], w[i][7:0]);
    end
    chk_word(mst_u.crc16(mst_u.rx_q), 16'h0000);
    mst_u.rx_q.delete();
    repeat (3 * GAP) @(posedge ref_clk); // scaled command spacing
  endtask
  task automatic expect_none;
    repeat (GAP + 4 * BYTE_T) @(posedge ref_clk);
    chk_word(16'(mst_u.rx_q.size()), 16'h0000);
  endtask
  // capture, then lose the drive board; a later update must be ignored
  task automatic t_full_read;
    upd <= 1'b1;
    @(posedge ref_clk);
    upd <= 1'b0;
    lost <= 1'b1;
    speed <= 16'hBEEF;
    @(posedge ref_clk);
    upd <= 1'b1;
    @(posedge ref_clk);
    upd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_word(status, STATUS_LINK_LOST);
    ask(SLAVE_ID_RESET, 8'h00, 8'h08, 1'b0);
    expect_reply(SLAVE_ID_RESET, '{16'h1234, 16'h0567, 16'h0000, 16'h0000, 16'h6543,
                 16'h2A10, 16'h0000, STATUS_LINK_LOST});
  endtask
  // foreign address and bad crc stay silent; a loaded address answers
  task automatic t_address;
    chk_byte(id_now, SLAVE_ID_RESET);
    ask(8'h2C, REG_STATUS, 8'h01, 1'b0);
    expect_none();
    id_val <= 8'h2C;
    id_load <= 1'b1;
    @(posedge ref_clk);
    id_load <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_byte(id_now, 8'h2C);
    ask(8'h2C, REG_SECONDS_LOW, 8'h01, 1'b1);
    expect_none();
    ask(8'h2C, REG_SECONDS_LOW, 8'h01, 1'b0);
    expect_reply(8'h2C, '{16'h2A10});
  endtask
  // a frozen enable ignores a load; a mid-run reset brings back the factory address
  task automatic t_freeze;
    id_val <= 8'h55;
    id_load <= 1'b1;
    clk_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    id_load <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk_byte(id_now, 8'h2C);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_byte(id_now, SLAVE_ID_RESET);
    chk_word(status, STATUS_LINK_LOST);
  endtask
  // reset, then the scenarios
  initial begin
    {rst, clk_en} = 2'b11;
    {id_load, upd, lost} = 3'b000;
    epoch = 32'h6543_2A10;
    speed = 16'h1234;
    current = 16'h0567;
    id_val = 8'h00;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_full_read();
    t_address();
    t_freeze();
    wrap_up();
  end
endmodule

// [verilog/byte_link_if.sv]
// interface: byte strobes between the frame engine and the serial shifter
`timescale 1ns/1ns
interface byte_link_if;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic [7:0] tx_data;
  logic       tx_start;
  logic       tx_busy;
  modport engine (input rx_data, input rx_valid, output tx_data, output tx_start,
                  input tx_busy);
  modport shifter (output rx_data, output rx_valid, input tx_data, input tx_start,
                   output tx_busy);
endinterface

// [verilog/hreg_pkg.sv]
// package: constants for the serial holding-register slave
package hreg_pkg;
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BAUD             = 19_200;
  localparam int unsigned BIT_CYCLES       = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS        = 8;
  localparam int unsigned STOP_BITS        = 1;
  localparam int unsigned GAP_MS           = 20;
  localparam int unsigned GAP_CYCLES       = (CLK_HZ / 1000) * GAP_MS;
  localparam logic [7:0]  FUNC_READ_HOLD   = 8'h03;
  localparam logic [7:0]  REG_SECONDS_HIGH = 8'h04;
  localparam logic [7:0]  REG_SECONDS_LOW  = 8'h05;
  localparam logic [7:0]  REG_STATUS       = 8'h07;
  localparam int unsigned NUM_REGS         = 16;
  localparam int unsigned MAX_COUNT        = 16;
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'hA001;
  localparam logic [15:0] STATUS_OK        = 16'h0000;
  localparam logic [15:0] STATUS_LINK_LOST = 16'h0001;
  localparam logic [7:0]  SLAVE_ID_RESET   = 8'h01;
  localparam int unsigned REQ_BYTES        = 8;
endpackage

// [verilog/hreg_slave.sv]
// module: serial holding-register slave answering read requests
//
// What this block does
// RULE1 - link is 19200 baud, 8N1, no handshake
// RULE2 - master keeps byte gaps within 20 ms
// RULE3 - master spaces commands by 50 ms
// RULE4 - answer valid function 3 reads with data
// RULE5 - request: id, function, start, count, CRC
// RULE6 - reply: id, function, byte count, data, CRC
// RULE7 - master polls slaves one at a time
// RULE8 - register number indexes table directly from zero
// RULE9 - register 4 holds upper seconds word
// RULE10 - answer only own loadable slave identifier
// RULE11 - register 5 holds lower seconds word
// RULE12 - register 7 zero unless an error exists
// RULE13 - keep last drive values, flag lost contact
// RULE14 - CRC-16 low first, drop bad frames silently
// RULE15 - gap over limit ends frame, then process
`timescale 1ns/1ns
module hreg_slave
  import hreg_pkg::*;
#(
  parameter int unsigned GAP_LIMIT = GAP_CYCLES,
  parameter int unsigned BIT_LEN   = BIT_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic [31:0] epoch_seconds,
  input  wire logic        slave_id_load,
  input  wire logic [7:0]  slave_id_value,
  input  wire logic        drive_board_update,
  input  wire logic [15:0] drive_board_speed,
  input  wire logic [15:0] drive_board_current,
  input  wire logic        drive_board_lost,
  output logic [7:0]       slave_id_now,
  output logic [15:0]      system_status
);
  import hreg_pkg::*;

  // the gap counter is 24 bits wide; a limit beyond it is truncated to 24 bits in the compare and ends frames early
  if (GAP_LIMIT < 2 || GAP_LIMIT > 32'h00FF_FFFF) begin : g_gap_range
    $error("gap limit out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_CHECK, ST_SEND, ST_WAIT} st_t;
  typedef struct packed {
    st_t         st;
    logic [2:0]  rx_pipe;
    logic        rx_clean;
    logic [23:0] gap;
    logic [3:0]  nbytes;
    logic [63:0] frame;
    logic [15:0] crc;
    logic [7:0]  id;
    logic [15:0] speed;
    logic [15:0] current;
    logic [15:0] status;
    logic [7:0]  reg_idx;
    logic [7:0]  left;
    logic [2:0]  phase;
    logic [15:0] tx_crc;
    logic        tx_start;
    logic [7:0]  tx_data;
  } top_t;
  top_t t_reg, t_next;

  byte_link_if link ();

  uart_shifter #(.BIT_LEN(BIT_LEN)) u_shift (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .rxd_sync (t_reg.rx_clean),
    .txd      (txd),
    .link     (link.shifter)
  );

  // eight bit-serial steps of the modbus crc over a byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1); // [RULE14]
    end
    return r;
  endfunction

  // table read; unlisted registers read zero
  function automatic logic [15:0] reg_read(input top_t t, input logic [7:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx) // [RULE8]
      8'h00:            v = t.speed;                 // [RULE13]
      8'h01:            v = t.current;               // [RULE13]
      REG_SECONDS_HIGH: v = epoch_seconds[31:16];    // [RULE9]
      REG_SECONDS_LOW:  v = epoch_seconds[15:0];     // [RULE11]
      REG_STATUS:       v = t.status;                // [RULE12]
      default:          v = 16'h0000;
    endcase
    return v;
  endfunction

  logic [15:0] word;
  logic [15:0] start_reg;
  logic [15:0] count;
  assign word      = reg_read(t_reg, t_reg.reg_idx);
  assign start_reg = t_reg.frame[47:32];
  assign count     = t_reg.frame[31:16];

  // frame assembly, gap timing, check and reply sequencing
  always_comb begin
    t_next = t_reg;
    t_next.tx_start = 1'b0;
    // three-stage sampler; a level counts only once stages two and three agree,
    // so a metastable settle in stage two cannot reach the receiver
    t_next.rx_pipe = {t_reg.rx_pipe[1:0], rxd};
    if (t_reg.rx_pipe[2] == t_reg.rx_pipe[1]) t_next.rx_clean = t_reg.rx_pipe[2];
    if (slave_id_load) t_next.id = slave_id_value; // [RULE10]
    if (drive_board_update && !drive_board_lost) begin
      t_next.speed   = drive_board_speed;   // [RULE13]
      t_next.current = drive_board_current;
    end
    t_next.status = drive_board_lost ? STATUS_LINK_LOST : STATUS_OK; // [RULE12]
    case (t_reg.st)
      ST_IDLE: begin
        if (link.rx_valid) begin
          t_next.st     = ST_RECV;
          t_next.frame  = {56'h0, link.rx_data};
          t_next.nbytes = 4'h1;
          t_next.gap    = 24'h0;
        end
      end
      ST_RECV: begin
        if (link.rx_valid) begin
          t_next.frame  = {t_reg.frame[55:0], link.rx_data};
          t_next.nbytes = (t_reg.nbytes == 4'hF) ? 4'hF : t_reg.nbytes + 4'h1;
          t_next.gap    = 24'h0;
        end else if (t_reg.gap >= 24'(GAP_LIMIT)) begin
          t_next.st = ST_CHECK; // [RULE15]
        end else begin
          t_next.gap = t_reg.gap + 24'h1;
        end
      end
      ST_CHECK: begin
        t_next.st = ST_IDLE;
        t_next.crc = CRC_INIT;
        for (int k = 7; k >= 2; k--) begin
          t_next.crc = crc_byte(t_next.crc, t_reg.frame[k*8 +: 8]);
        end
        // long or short frames and mismatches are dropped with no answer
        if (t_reg.nbytes == 4'(REQ_BYTES) && t_reg.frame[63:56] == t_reg.id &&
            t_reg.frame[55:48] == FUNC_READ_HOLD &&
            t_next.crc == {t_reg.frame[7:0], t_reg.frame[15:8]} && // [RULE14]
            count != 16'h0 && count <= 16'(MAX_COUNT) &&
            start_reg < 16'(NUM_REGS)) begin // [RULE4] [RULE10]
          t_next.st      = ST_SEND;
          t_next.reg_idx = start_reg[7:0];
          t_next.left    = count[7:0];
          t_next.phase   = 3'h0;
          t_next.tx_crc  = CRC_INIT;
        end
      end
      ST_SEND: begin
        if (!link.tx_busy) begin
          t_next.tx_start = 1'b1;
          t_next.phase    = t_reg.phase + 3'h1;
          case (t_reg.phase) // [RULE6]
            3'h0: t_next.tx_data = t_reg.id;
            3'h1: t_next.tx_data = FUNC_READ_HOLD;
            3'h2: t_next.tx_data = {t_reg.left[6:0], 1'b0};
            3'h3: t_next.tx_data = word[15:8];
            3'h4: begin
              t_next.tx_data = word[7:0];
              t_next.reg_idx = t_reg.reg_idx + 8'h1;
              t_next.left    = t_reg.left - 8'h1;
              if (t_reg.left != 8'h1) t_next.phase = 3'h3;
            end
            3'h5: t_next.tx_data = t_reg.tx_crc[7:0];  // [RULE14]
            3'h6: begin
              t_next.tx_data = t_reg.tx_crc[15:8];
              t_next.st      = ST_WAIT;
            end
            default: t_next.tx_start = 1'b0;
          endcase
          if (t_reg.phase < 3'h5) t_next.tx_crc = crc_byte(t_reg.tx_crc, t_next.tx_data);
        end
      end
      ST_WAIT: begin
        // bytes heard while answering are ignored; the master waits for us
        if (!link.tx_busy) t_next.st = ST_IDLE; // [RULE7]
      end
      default: t_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      t_reg <= '{st: ST_IDLE, rx_pipe: 3'b111, rx_clean: 1'b1, gap: 24'h0, nbytes: 4'h0,
                 frame: 64'h0, crc: 16'h0, id: SLAVE_ID_RESET, speed: 16'h0,
                 current: 16'h0, status: STATUS_OK, reg_idx: 8'h0, left: 8'h0,
                 phase: 3'h0, tx_crc: 16'h0, tx_start: 1'b0, tx_data: 8'h0};
    end else if (clk_en) begin
      t_reg <= t_next;
    end
  end

  assign link.tx_start = t_reg.tx_start;
  assign link.tx_data  = t_reg.tx_data;
  assign slave_id_now  = t_reg.id;
  assign system_status = t_reg.status;
endmodule

// [verilog/uart_shifter.sv]
// module: 19200 8N1 receive and transmit shifter
`timescale 1ns/1ns
module uart_shifter
  import hreg_pkg::*;
#(
  parameter int unsigned BIT_LEN = BIT_CYCLES
)
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   clk_en,
  input  wire logic   rxd_sync,
  output logic        txd,
  byte_link_if.shifter link
);
  typedef struct packed {
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic        rx_act;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic        tx_act;
    logic [9:0]  tx_sh;
    logic        txd;
  } sh_t;
  sh_t s_reg, s_next;
  localparam logic [15:0] BITC = 16'(BIT_LEN);
  localparam logic [15:0] HALF = 16'(BIT_LEN / 2);

  // the bit counter is 16 bits wide and needs a distinct mid-bit point
  if (BIT_LEN < 4 || BIT_LEN > 32'h0000_FFFF) begin : g_bit_range
    $error("bit length out of range");
  end

  // receive samples mid-bit; transmit shifts start, 8 data, one stop
  always_comb begin
    s_next = s_reg;
    s_next.rx_valid = 1'b0;
    if (!s_reg.rx_act) begin
      if (!rxd_sync) begin
        s_next.rx_act = 1'b1;
        s_next.rx_cnt = HALF;
        s_next.rx_bit = 4'h0;
      end
    end else if (s_reg.rx_cnt != 16'h0000) begin
      s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
    end else begin
      s_next.rx_cnt = BITC - 16'h0001;
      s_next.rx_bit = s_reg.rx_bit + 4'h1;
      if (s_reg.rx_bit == 4'h0) begin
        if (rxd_sync) s_next.rx_act = 1'b0; // false start glitch
      end else if (s_reg.rx_bit <= 4'(DATA_BITS)) begin
        s_next.rx_sh = {rxd_sync, s_reg.rx_sh[7:1]}; // [RULE1]
      end else begin
        s_next.rx_act = 1'b0;
        if (rxd_sync) begin // framing error drops the byte [RULE1]
          s_next.rx_data  = s_reg.rx_sh;
          s_next.rx_valid = 1'b1;
        end
      end
    end
    if (!s_reg.tx_act) begin
      s_next.txd = 1'b1;
      if (link.tx_start) begin
        s_next.tx_act = 1'b1;
        s_next.tx_sh  = {1'b1, link.tx_data, 1'b0}; // [RULE1]
        s_next.tx_bit = 4'h0;
        s_next.tx_cnt = BITC - 16'h0001;
        s_next.txd    = 1'b0;
      end
    end else if (s_reg.tx_cnt != 16'h0000) begin
      s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
    end else begin
      s_next.tx_cnt = BITC - 16'h0001;
      s_next.tx_bit = s_reg.tx_bit + 4'h1;
      s_next.tx_sh  = {1'b1, s_reg.tx_sh[9:1]};
      s_next.txd    = s_reg.tx_sh[1];
      if (s_reg.tx_bit == 4'(DATA_BITS + STOP_BITS)) begin
        s_next.tx_act = 1'b0;
        s_next.txd    = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '{rx_cnt: 16'h0000, rx_bit: 4'h0, rx_act: 1'b0, rx_sh: 8'h00,
                 rx_data: 8'h00, rx_valid: 1'b0, tx_cnt: 16'h0000, tx_bit: 4'h0,
                 tx_act: 1'b0, tx_sh: 10'h3FF, txd: 1'b1};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign txd           = s_reg.txd;
  assign link.rx_data  = s_reg.rx_data;
  assign link.rx_valid = s_reg.rx_valid;
  assign link.tx_busy  = s_reg.tx_act | link.tx_start;
endmodule
